/* File: common/metering_regs_pkg.sv */
// Purpose: shared constants, types and carriers of the metering register bank
// Assumes: 32-bit APB data, 16-bit registers in the low half of each word
// Notes: register offsets are word indices; byte address is four times the index
package metering_regs_pkg;

	// ****************************************
	// bus geometry
	// ****************************************
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;
	localparam int unsigned IDX_W = 12;

	// ****************************************
	// register indices
	// ****************************************
	localparam logic [11:0] PROT_CFG3_IDX = 12'h493;
	localparam logic [11:0] CROSS_PERIOD_IDX = 12'h49A;
	localparam logic [11:0] SIGN_FLAGS_IDX = 12'h49D;
	localparam logic [11:0] WAVE_CFG_IDX = 12'h4A0;
	localparam logic [11:0] SIGN_SEL_IDX = 12'h4B0;

	// ****************************************
	// field positions
	// ****************************************
	localparam int unsigned OVERCURRENT_PHASE_ENABLES_LSB = 12;
	localparam int unsigned PEAK_LSB = 2;
	localparam int unsigned PERIOD_LSB = 3;
	localparam int unsigned CROSS_LSB = 1;
	localparam int unsigned NEUTRAL_RD_BIT = 12;
	localparam int unsigned WAVE_SRC_LSB = 8;
	localparam int unsigned FILL_LSB = 6;
	localparam int unsigned SUM_SIGN_LSB = 6;
	localparam int unsigned PHASE_SIGN_LSB = 0;
	localparam int unsigned SIGN_SEL_BIT = 0;

	// ****************************************
	// reset values and writable masks
	// ****************************************
	localparam logic [15:0] PROT_CFG3_RST = 16'hF000;
	localparam logic [15:0] CROSS_PERIOD_RST = 16'h001E;
	localparam logic [15:0] WAVE_CFG_RST = 16'h0000;
	localparam logic [15:0] SIGN_SEL_RST = 16'h0000;
	localparam logic [15:0] SIGN_FLAGS_RST = 16'h0000;
	localparam logic [15:0] PROT_CFG3_MASK = 16'hF01C;
	localparam logic [15:0] CROSS_PERIOD_MASK = 16'h001E;
	localparam logic [15:0] WAVE_CFG_MASK = 16'h13C0;
	localparam logic [15:0] SIGN_SEL_MASK = 16'h0001;

	// ****************************************
	// mode encodings
	// ****************************************
	typedef enum logic [1:0] {
		PERIOD_PHASE_A = 2'h0,
		PERIOD_PHASE_B = 2'h1,
		PERIOD_PHASE_C = 2'h2,
		PERIOD_COMBINED = 2'h3
	} period_src_t;

	typedef enum logic [1:0] {
		CROSS_PHASE_A = 2'h0,
		CROSS_PHASE_B = 2'h1,
		CROSS_PHASE_C = 2'h2,
		CROSS_COMBINED = 2'h3
	} crossing_src_t;

	typedef enum logic [1:0] {
		WAVE_SINC_32K = 2'h0,
		WAVE_RSVD_01 = 2'h1,
		WAVE_SINC_LPF_8K = 2'h2,
		WAVE_RSVD_11 = 2'h3
	} wave_src_t;

	typedef enum logic [1:0] {
		FILL_STOP_FULL = 2'h0,
		FILL_CONT_TRIGGER = 2'h1,
		FILL_CENTER_TRIGGER = 2'h2,
		FILL_SAVE_ADDRESS = 2'h3
	} fill_policy_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'h0,
		BUS_RESPOND = 2'h1
	} bus_state_t;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned FAST_RATE_HZ = 32_000;
	localparam int unsigned SLOW_RATE_HZ = 8_000;
	localparam int unsigned FAST_STROBE_CYCLES = CLK_HZ / FAST_RATE_HZ;
	localparam int unsigned SLOW_STROBE_CYCLES = CLK_HZ / SLOW_RATE_HZ;
	localparam int unsigned STROBE_CNT_W = 14;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	typedef struct packed {
		logic [3:0] sum;
		logic [5:0] total;
		logic [5:0] fund;
	} power_signs_t;

endpackage

/* File: verilog/sample_strobe_timer.sv */
// Purpose: data-ready strobe generator at one of two sample rates
// Assumes: counts are at least two cycles
// Notes: restarts its count whenever the rate changes
`timescale 1ns/1ps
`default_nettype none
module sample_strobe_timer #(
	parameter int unsigned FAST_CYCLES = metering_regs_pkg::FAST_STROBE_CYCLES,
	parameter int unsigned SLOW_CYCLES = metering_regs_pkg::SLOW_STROBE_CYCLES
) (
	// clock and control
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// rate select
	input wire logic slow_rate_in,
	// strobe
	output logic strobe_out
);

	localparam int unsigned CW = metering_regs_pkg::STROBE_CNT_W;
	localparam logic [CW-1:0] FAST_LAST = CW'(FAST_CYCLES - 1);
	localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_CYCLES - 1);

	logic [CW-1:0] count_reg;
	logic slow_reg;
	logic [CW-1:0] last;

	assign last = slow_rate_in ? SLOW_LAST : FAST_LAST;

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			count_reg <= '0;
			slow_reg <= 1'b0;
			strobe_out <= 1'b0;
		end else if (ce_in) begin
			slow_reg <= slow_rate_in;
			if (slow_reg != slow_rate_in || count_reg >= last) begin
				count_reg <= '0;
			end else begin
				count_reg <= count_reg + 1'b1;
			end
			strobe_out <= (slow_reg == slow_rate_in) && (count_reg == last);
		end
	end

endmodule
`default_nettype wire

/* File: verilog/metering_config_status_regs.sv */
// Purpose: configuration and status registers of the metering core over APB
// Assumes: sign and crossing inputs come from logic on sys_clk_in
// Notes: one wait state on every transfer
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module metering_config_status_regs #(
	parameter int unsigned PERIOD_W = 32,
	parameter int unsigned SLOW_CYCLES = metering_regs_pkg::SLOW_STROBE_CYCLES
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// register bus
	input wire metering_regs_pkg::apb_req_t apb_in,
	output metering_regs_pkg::apb_rsp_t apb_out,
	// measurement inputs
	input wire logic [PERIOD_W-1:0] phase_a_line_period_in,
	input wire logic [PERIOD_W-1:0] phase_b_line_period_in,
	input wire logic [PERIOD_W-1:0] phase_c_line_period_in,
	input wire logic [PERIOD_W-1:0] combined_line_period_in,
	input wire logic phase_a_voltage_crossing_in,
	input wire logic phase_b_voltage_crossing_in,
	input wire logic phase_c_voltage_crossing_in,
	input wire logic combined_voltage_crossing_in,
	input wire metering_regs_pkg::power_signs_t power_signs_in,
	// controls to the metering core
	output logic [3:0] overcurrent_phase_enables_out,
	output logic [2:0] peak_phase_select_out,
	output logic [PERIOD_W-1:0] selected_line_period_out,
	output logic selected_crossing_out,
	output logic neutral_wave_readout_enable_out,
	output metering_regs_pkg::wave_src_t wave_buffer_source_out,
	output metering_regs_pkg::fill_policy_t wave_fill_policy_out,
	output logic sample_ready_strobe_out
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] byte_addr(input logic [11:0] idx);
		byte_addr = {2'b00, idx, 2'b00};
	endfunction

	function automatic logic [15:0] masked(input logic [15:0] old_val, input logic [15:0] wr,
		input logic [15:0] mask);
		masked = (old_val & ~mask) | (wr & mask);
	endfunction

	// ****************************************
	// storage
	// ****************************************
	logic [15:0] prot_cfg3_reg;
	logic [15:0] cross_period_reg;
	logic [15:0] wave_cfg_reg;
	logic [15:0] sign_sel_reg;
	logic [15:0] sign_flags_reg;
	metering_regs_pkg::bus_state_t bus_state_reg;

	logic access;
	logic do_write;
	logic [15:0] wdata;
	logic hit_cfg3;
	logic hit_cross;
	logic hit_flags;
	logic hit_wave;
	logic hit_sel;
	logic mapped;
	logic [15:0] rd_val;
	metering_regs_pkg::period_src_t period_sel;
	metering_regs_pkg::crossing_src_t cross_sel;
	metering_regs_pkg::wave_src_t wave_src;

	// ****************************************
	// address decode
	// ****************************************
	assign access = apb_in.psel && apb_in.penable;
	assign wdata = apb_in.pwdata[15:0];
	assign hit_cfg3 = apb_in.paddr == byte_addr(metering_regs_pkg::PROT_CFG3_IDX);
	assign hit_cross = apb_in.paddr == byte_addr(metering_regs_pkg::CROSS_PERIOD_IDX);
	assign hit_flags = apb_in.paddr == byte_addr(metering_regs_pkg::SIGN_FLAGS_IDX);
	assign hit_wave = apb_in.paddr == byte_addr(metering_regs_pkg::WAVE_CFG_IDX);
	assign hit_sel = apb_in.paddr == byte_addr(metering_regs_pkg::SIGN_SEL_IDX);
	assign mapped = hit_cfg3 || hit_cross || hit_flags || hit_wave || hit_sel;
	assign do_write = access && apb_in.pwrite && (bus_state_reg == metering_regs_pkg::BUS_RESPOND);

	always_comb begin
		rd_val = 16'h0000;
		if (hit_cfg3) begin
			rd_val = prot_cfg3_reg;
		end else if (hit_cross) begin
			rd_val = cross_period_reg;
		end else if (hit_flags) begin
			rd_val = sign_flags_reg;
		end else if (hit_wave) begin
			rd_val = wave_cfg_reg;
		end else if (hit_sel) begin
			rd_val = sign_sel_reg;
		end
	end

	// ****************************************
	// bus handshake
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			bus_state_reg <= metering_regs_pkg::BUS_IDLE;
			apb_out <= '0;
		end else if (ce_in) begin
			unique case (bus_state_reg)
				metering_regs_pkg::BUS_IDLE: begin
					apb_out.pready <= 1'b0;
					apb_out.pslverr <= 1'b0;
					if (access) begin
						bus_state_reg <= metering_regs_pkg::BUS_RESPOND;
						apb_out.pready <= 1'b1;
						apb_out.pslverr <= !mapped;
						apb_out.prdata <= {16'h0000, rd_val};
					end
				end
				metering_regs_pkg::BUS_RESPOND: begin
					bus_state_reg <= metering_regs_pkg::BUS_IDLE;
					apb_out.pready <= 1'b0;
					apb_out.pslverr <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// writable registers
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			prot_cfg3_reg <= metering_regs_pkg::PROT_CFG3_RST;
		end else if (ce_in && do_write && hit_cfg3) begin
			prot_cfg3_reg <= masked(prot_cfg3_reg, wdata, metering_regs_pkg::PROT_CFG3_MASK);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			cross_period_reg <= metering_regs_pkg::CROSS_PERIOD_RST;
		end else if (ce_in && do_write && hit_cross) begin
			cross_period_reg <= masked(cross_period_reg, wdata,
				metering_regs_pkg::CROSS_PERIOD_MASK);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			wave_cfg_reg <= metering_regs_pkg::WAVE_CFG_RST;
		end else if (ce_in && do_write && hit_wave) begin
			wave_cfg_reg <= masked(wave_cfg_reg, wdata, metering_regs_pkg::WAVE_CFG_MASK);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sign_sel_reg <= metering_regs_pkg::SIGN_SEL_RST;
		end else if (ce_in && do_write && hit_sel) begin
			sign_sel_reg <= masked(sign_sel_reg, wdata, metering_regs_pkg::SIGN_SEL_MASK);
		end
	end

	// ****************************************
	// sign flags, read only
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			sign_flags_reg <= metering_regs_pkg::SIGN_FLAGS_RST;
		end else if (ce_in) begin
			sign_flags_reg <= 16'h0000;
			sign_flags_reg[metering_regs_pkg::SUM_SIGN_LSB +: 4] <= power_signs_in.sum;
			if (sign_sel_reg[metering_regs_pkg::SIGN_SEL_BIT]) begin
				sign_flags_reg[metering_regs_pkg::PHASE_SIGN_LSB +: 6] <= power_signs_in.fund;
			end else begin
				sign_flags_reg[metering_regs_pkg::PHASE_SIGN_LSB +: 6] <= power_signs_in.total;
			end
		end
	end

	// ****************************************
	// source selection
	// ****************************************
	assign period_sel = metering_regs_pkg::period_src_t'(
		cross_period_reg[metering_regs_pkg::PERIOD_LSB +: 2]);
	assign cross_sel = metering_regs_pkg::crossing_src_t'(
		cross_period_reg[metering_regs_pkg::CROSS_LSB +: 2]);
	assign wave_src = metering_regs_pkg::wave_src_t'(
		wave_cfg_reg[metering_regs_pkg::WAVE_SRC_LSB +: 2]);

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			selected_line_period_out <= '0;
		end else if (ce_in) begin
			unique case (period_sel)
				metering_regs_pkg::PERIOD_PHASE_A: selected_line_period_out <= phase_a_line_period_in;
				metering_regs_pkg::PERIOD_PHASE_B: selected_line_period_out <= phase_b_line_period_in;
				metering_regs_pkg::PERIOD_PHASE_C: selected_line_period_out <= phase_c_line_period_in;
				metering_regs_pkg::PERIOD_COMBINED: selected_line_period_out <= combined_line_period_in;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			selected_crossing_out <= 1'b0;
		end else if (ce_in) begin
			unique case (cross_sel)
				metering_regs_pkg::CROSS_PHASE_A: selected_crossing_out <= phase_a_voltage_crossing_in;
				metering_regs_pkg::CROSS_PHASE_B: selected_crossing_out <= phase_b_voltage_crossing_in;
				metering_regs_pkg::CROSS_PHASE_C: selected_crossing_out <= phase_c_voltage_crossing_in;
				metering_regs_pkg::CROSS_COMBINED: selected_crossing_out <= combined_voltage_crossing_in;
			endcase
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			overcurrent_phase_enables_out <= 4'hF;
			peak_phase_select_out <= 3'h0;
			neutral_wave_readout_enable_out <= 1'b0;
			wave_buffer_source_out <= metering_regs_pkg::WAVE_SINC_32K;
			wave_fill_policy_out <= metering_regs_pkg::FILL_STOP_FULL;
		end else if (ce_in) begin
			// bit 0 phase A, 1 phase B, 2 phase C, 3 neutral
			overcurrent_phase_enables_out <= prot_cfg3_reg[metering_regs_pkg::OVERCURRENT_PHASE_ENABLES_LSB +: 4];
			peak_phase_select_out <= prot_cfg3_reg[metering_regs_pkg::PEAK_LSB +: 3];
			neutral_wave_readout_enable_out <= wave_cfg_reg[metering_regs_pkg::NEUTRAL_RD_BIT];
			wave_buffer_source_out <= wave_src;
			wave_fill_policy_out <= metering_regs_pkg::fill_policy_t'(
				wave_cfg_reg[metering_regs_pkg::FILL_LSB +: 2]);
		end
	end

	// ****************************************
	// data-ready strobe
	// ****************************************
	sample_strobe_timer #(
		.FAST_CYCLES(metering_regs_pkg::FAST_STROBE_CYCLES),
		.SLOW_CYCLES(SLOW_CYCLES)
	) u_strobe (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.slow_rate_in(wave_src == metering_regs_pkg::WAVE_SINC_LPF_8K),
		.strobe_out(sample_ready_strobe_out)
	);

endmodule
`default_nettype wire

/* File: verification/metering_config_status_regs_checker.sv */
// Purpose: timing checks on the metering register bank ports
// Assumes: ce_in high whenever a transfer runs
// Notes: bound into every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module metering_config_status_regs_checker #(
	parameter int unsigned PERIOD_W = 32
) (
	// clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// register bus
	input wire metering_regs_pkg::apb_req_t apb_in,
	input wire metering_regs_pkg::apb_rsp_t apb_out,
	// measurements
	input wire logic [PERIOD_W-1:0] phase_a_line_period_in,
	input wire logic [PERIOD_W-1:0] phase_b_line_period_in,
	input wire logic [PERIOD_W-1:0] phase_c_line_period_in,
	input wire logic [PERIOD_W-1:0] combined_line_period_in,
	input wire logic phase_a_voltage_crossing_in,
	input wire logic phase_b_voltage_crossing_in,
	input wire logic phase_c_voltage_crossing_in,
	input wire logic combined_voltage_crossing_in,
	// controls
	input wire logic [3:0] overcurrent_phase_enables_out,
	input wire logic [2:0] peak_phase_select_out,
	input wire logic [PERIOD_W-1:0] selected_line_period_out,
	input wire logic selected_crossing_out,
	input wire logic neutral_wave_readout_enable_out,
	input wire metering_regs_pkg::wave_src_t wave_buffer_source_out,
	input wire metering_regs_pkg::fill_policy_t wave_fill_policy_out,
	input wire logic sample_ready_strobe_out
);
	// ****************************************
	// mirror of the source codes
	// ****************************************
	logic [1:0] period_code_reg;
	logic [1:0] cross_code_reg;
	logic [PERIOD_W-1:0] period_pick;
	logic [3:0] crossings;
	logic mapped;
	always_comb begin
		mapped = apb_in.paddr inside {16'h124C, 16'h1268, 16'h1274, 16'h1280, 16'h12C0};
		crossings = {combined_voltage_crossing_in, phase_c_voltage_crossing_in,
			phase_b_voltage_crossing_in, phase_a_voltage_crossing_in};
		case (period_code_reg)
			2'h0: period_pick = phase_a_line_period_in;
			2'h1: period_pick = phase_b_line_period_in;
			2'h2: period_pick = phase_c_line_period_in;
			default: period_pick = combined_line_period_in;
		endcase
	end
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			period_code_reg <= 2'h3;
			cross_code_reg <= 2'h3;
		end else if (ce_in && apb_in.psel && apb_in.penable && apb_out.pready
			&& apb_in.pwrite && apb_in.paddr == 16'h1268) begin
			period_code_reg <= apb_in.pwdata[4:3];
			cross_code_reg <= apb_in.pwdata[2:1];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	sequence s_access;
		apb_in.psel && apb_in.penable && !apb_out.pready && ce_in;
	endsequence
	sequence s_wr(logic [15:0] addr);
		apb_in.psel && apb_in.penable && apb_out.pready && apb_in.pwrite && apb_in.paddr == addr;
	endsequence
	a_ready_wait: assert property (s_access |=> apb_out.pready)
		else $error("no ready one cycle after access");
	a_ready_pulse: assert property (apb_out.pready |=> !apb_out.pready)
		else $error("ready held longer than a cycle");
	a_ready_cause: assert property (apb_out.pready |-> $past(apb_in.psel && apb_in.penable))
		else $error("ready without access phase");
	a_error_map: assert property (apb_out.pready |-> apb_out.pslverr == !mapped)
		else $error("error flag wrong for address");
	a_upper_zero: assert property (apb_out.pready |-> apb_out.prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_oc_follow: assert property (s_wr(16'h124C) |-> ##2
		overcurrent_phase_enables_out == $past(apb_in.pwdata[15:12], 2))
		else $error("overcurrent enables differ from write");
	a_peak_follow: assert property (s_wr(16'h124C) |-> ##2
		peak_phase_select_out == $past(apb_in.pwdata[4:2], 2))
		else $error("peak select differs from write");
	a_wave_follow: assert property (s_wr(16'h1280) |-> ##2
		{neutral_wave_readout_enable_out, wave_buffer_source_out, wave_fill_policy_out}
		== $past({apb_in.pwdata[12], apb_in.pwdata[9:6]}, 2))
		else $error("wave outputs differ from write");
	a_period_mux: assert property (!$past(srst_in) && $past(ce_in) |->
		selected_line_period_out == $past(period_pick))
		else $error("selected period wrong");
	a_cross_mux: assert property (!$past(srst_in) && $past(ce_in) |->
		selected_crossing_out == $past(crossings[cross_code_reg]))
		else $error("selected crossing wrong");
	a_strobe_gap: assert property (sample_ready_strobe_out |=> !sample_ready_strobe_out [*8])
		else $error("strobes too close");
endmodule
bind metering_config_status_regs metering_config_status_regs_checker #(.PERIOD_W(PERIOD_W)) chk (
	.sys_clk_in, .srst_in, .ce_in, .apb_in, .apb_out,
	.phase_a_line_period_in, .phase_b_line_period_in, .phase_c_line_period_in,
	.combined_line_period_in, .phase_a_voltage_crossing_in, .phase_b_voltage_crossing_in,
	.phase_c_voltage_crossing_in, .combined_voltage_crossing_in,
	.overcurrent_phase_enables_out, .peak_phase_select_out, .selected_line_period_out,
	.selected_crossing_out, .neutral_wave_readout_enable_out, .wave_buffer_source_out,
	.wave_fill_policy_out, .sample_ready_strobe_out
);
`default_nettype wire

/* File: verification/metering_config_status_regs_bench.sv */
// Purpose: self-checking bench of the metering register bank
// Assumes: one wait state per transfer, short slow strobe count
// Notes: bus results are compared by a monitor against queued notes
`timescale 1ns/1ps
`default_nettype none
module metering_config_status_regs_bench;
	localparam int SLOW = 20;
	localparam logic [15:0] ADR [5] = '{16'h124C, 16'h1268, 16'h1274, 16'h1280, 16'h12C0};
	localparam logic [31:0] MSK [5] = '{32'h0000F01C, 32'h0000001E, 32'h0, 32'h000013C0, 32'h1};
	typedef struct packed {
		logic [31:0] mask;
		logic [31:0] data;
		logic err;
	} note_t;
	logic sys_clk_in;
	logic srst_in;
	logic ce_in;
	metering_regs_pkg::apb_req_t apb_in;
	metering_regs_pkg::apb_rsp_t apb_out;
	logic [31:0] per [4];
	logic [3:0] zx;
	metering_regs_pkg::power_signs_t signs;
	logic [3:0] oc;
	logic [2:0] peak;
	logic [31:0] sel_per;
	logic sel_zx;
	logic nin;
	metering_regs_pkg::wave_src_t wsrc;
	metering_regs_pkg::fill_policy_t fill;
	logic strobe;
	int mismatches;
	int comparisons;
	logic [31:0] v;
	note_t cur;
	note_t notes [$];
	metering_config_status_regs #(.SLOW_CYCLES(SLOW)) dut (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .ce_in(ce_in),
		.apb_in(apb_in), .apb_out(apb_out),
		.phase_a_line_period_in(per[0]), .phase_b_line_period_in(per[1]),
		.phase_c_line_period_in(per[2]), .combined_line_period_in(per[3]),
		.phase_a_voltage_crossing_in(zx[0]), .phase_b_voltage_crossing_in(zx[1]),
		.phase_c_voltage_crossing_in(zx[2]), .combined_voltage_crossing_in(zx[3]),
		.power_signs_in(signs), .overcurrent_phase_enables_out(oc),
		.peak_phase_select_out(peak), .selected_line_period_out(sel_per),
		.selected_crossing_out(sel_zx), .neutral_wave_readout_enable_out(nin),
		.wave_buffer_source_out(wsrc), .wave_fill_policy_out(fill),
		.sample_ready_strobe_out(strobe)
	);
	// ****************************************
	// checking and bus tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
		comparisons++;
		if (got !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, got);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [31:0] m, input logic err);
		int n;
		notes.push_back('{m, e, err});
		apb_in.psel <= 1'b1;
		apb_in.pwrite <= w;
		apb_in.paddr <= a;
		apb_in.pwdata <= d;
		@(posedge sys_clk_in);
		apb_in.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
		end while (apb_out.pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			give_verdict();
		end
		apb_in.penable <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic err);
		xfer(1'b0, a, 32'h0, e, 32'hFFFFFFFF, err);
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask
	task automatic idle(input int n);
		apb_in.psel <= 1'b0;
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic gap(input int e);
		int n;
		idle(3);
		n = 0;
		while (strobe !== 1'b1 && n < 20000) begin
			@(posedge sys_clk_in);
			n++;
		end
		@(posedge sys_clk_in);
		n = 1;
		while (strobe !== 1'b1 && n < 20000) begin
			@(posedge sys_clk_in);
			n++;
		end
		check("strobe gap", e, n);
	endtask
	always @(posedge sys_clk_in) begin
		if (apb_out.pready === 1'b1) begin
			cur = notes.pop_front();
			check("prdata", cur.data & cur.mask, apb_out.prdata & cur.mask);
			check("pslverr", {31'h0, cur.err}, {31'h0, apb_out.pslverr});
		end
	end
	// ****************************************
	// clock, watchdog and scenarios
	// ****************************************
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (100000) @(posedge sys_clk_in);
		mismatches++;
		give_verdict();
	end
	initial begin
		srst_in = 1'b1;
		ce_in = 1'b1;
		apb_in = '0;
		per = '{default: 32'h0};
		zx = 4'h0;
		signs = '0;
		mismatches = 0;
		comparisons = 0;
		v = $urandom(34);
		repeat (20) @(posedge sys_clk_in);
		srst_in <= 1'b0;
		rd(ADR[0], 32'h0000F000, 1'b0);
		rd(ADR[1], 32'h0000001E, 1'b0);
		rd(ADR[2], 32'h0, 1'b0);
		rd(ADR[3], 32'h0, 1'b0);
		idle(2);
		check("oc reset", 32'hF, {28'h0, oc});
		rd(16'h1250, 32'h0, 1'b1);
		rd(16'h124E, 32'h0, 1'b1);
		xfer(1'b1, 16'h0FFC, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(ADR[i], 32'hFFFFFFFF);
			rd(ADR[i], MSK[i], 1'b0);
		end
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr(ADR[0], v);
			rd(ADR[0], v & 32'h0000F01C, 1'b0);
			idle(2);
			check("oc", {28'h0, v[15:12]}, {28'h0, oc});
			check("peak", {29'h0, v[4:2]}, {29'h0, peak});
		end
		for (int c = 0; c < 4; c++) begin
			foreach (per[j]) per[j] <= $urandom;
			zx <= 4'($urandom);
			v = ($urandom & 32'hFFFFFFE1) | (c << 3) | ((3 - c) << 1);
			wr(ADR[1], v);
			idle(3);
			check("period", per[c], sel_per);
			check("crossing", {31'h0, zx[3 - c]}, {31'h0, sel_zx});
		end
		for (int s = 0; s < 2; s++) begin
			signs <= 16'($urandom);
			wr(ADR[4], s);
			v = {22'h0, signs.sum, s ? signs.fund : signs.total};
			rd(ADR[2], v, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			v = ($urandom & 32'hFFFFEC3F) | {i[0], 2'h0, i[1:0], i[2:1], 6'h0};
			wr(ADR[3], v);
			rd(ADR[3], v & 32'h000013C0, 1'b0);
			idle(2);
			check("wave", {27'h0, v[12], v[9:6]}, {27'h0, nin, wsrc, fill});
		end
		wr(ADR[3], 32'h00000200);
		gap(SLOW);
		wr(ADR[3], 32'h0);
		gap(metering_regs_pkg::FAST_STROBE_CYCLES);
		give_verdict();
	end
endmodule
`default_nettype wire
